// file: rtl/rsw_reset_wdt.sv
// reset source combiner, start-up delay and watchdog with bus registers
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps

module rsw_reset_wdt #(
    parameter int unsigned STARTUP_CYCLES = rsw_pkg::STARTUP_CYCLES
) (
    input  wire logic                     CORE_CLK,
    input  wire logic                     RST,
    input  wire logic                     RESET_N_PIN,
    input  wire logic                     EXT_RESET_EN,
    input  wire logic                     BOD_LOW,
    input  wire logic                     BOD_EN_FUSE,
    input  wire logic                     ALWAYS_ON_FUSE,
    input  wire logic                     WDT_OSC,
    input  wire logic                     WDT_CLEAR,
    input  wire logic                     IRQ_ACK,
    input  wire logic                     COMPARATOR_BANDGAP_SELECT,
    input  wire logic                     ADC_ENABLE,
    input  wire logic                     WB_CYC_I,
    input  wire logic                     WB_STB_I,
    input  wire logic                     WB_WE_I,
    input  wire logic [rsw_pkg::ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]               WB_SEL_I,
    input  wire logic [31:0]              WB_DAT_I,
    output logic                          WB_ACK_O,
    output logic [31:0]                   WB_DAT_O,
    output logic                          CHIP_RST,
    output logic                          WDT_RST_PULSE,
    output logic                          WDT_IRQ,
    output logic                          BANDGAP_ON
);
    import rsw_pkg::*;

    // expiry count for a period code; reserved codes act as the longest
    // explicit table keeps each of the ten lengths visible at a glance
    function automatic logic [WDT_W-1:0] wdt_limit(input logic [3:0] code);
        logic [WDT_W-1:0] cycles;
        case (code)
            4'h0:    cycles = WDT_BASE_CYCLES;         // 2K
            4'h1:    cycles = WDT_BASE_CYCLES << 4'h1; // 4K
            4'h2:    cycles = WDT_BASE_CYCLES << 4'h2; // 8K
            4'h3:    cycles = WDT_BASE_CYCLES << 4'h3; // 16K
            4'h4:    cycles = WDT_BASE_CYCLES << 4'h4; // 32K
            4'h5:    cycles = WDT_BASE_CYCLES << 4'h5; // 64K
            4'h6:    cycles = WDT_BASE_CYCLES << 4'h6; // 128K
            4'h7:    cycles = WDT_BASE_CYCLES << 4'h7; // 256K
            4'h8:    cycles = WDT_BASE_CYCLES << 4'h8; // 512K
            4'h9:    cycles = WDT_BASE_CYCLES << 4'h9; // 1024K
            default: cycles = WDT_BASE_CYCLES << WDT_MAX_CODE;
        endcase
        return cycles - 21'h000001;
    endfunction : wdt_limit

    localparam logic [DLY_W-1:0] DELAY_LAST =
        DLY_W'(STARTUP_CYCLES) - 24'h000001;

    rsw_state_t st_reg;
    rsw_state_t st_next;

    rsw_async_t async_in;
    logic       level2;
    logic       run_eff;
    logic       running;
    logic       osc_edge;
    logic       expire;
    logic       any_cause;
    logic       bus_req;
    logic       bus_wr;
    logic       ctrl_wr;
    logic       cause_wr;
    logic [7:0] wbyte;
    logic [3:0] w_per;
    logic       w_run;
    logic       w_unlock;

    // gather pins and fuses that arrive from outside this clock domain
    always_comb begin
        async_in.osc       = WDT_OSC;
        async_in.reset_n   = RESET_N_PIN;
        async_in.bod_low   = BOD_LOW;
        async_in.ext_en    = EXT_RESET_EN;
        async_in.bod_en    = BOD_EN_FUSE;
        async_in.always_on = ALWAYS_ON_FUSE;
    end

    // next state of the whole block
    always_comb begin
        st_next = st_reg;

        // two-stage synchroniser; only stage two is read below
        st_next.sync1 = async_in;
        st_next.sync2 = st_reg.sync1;

        // fuse decides safety level; level 2 pins the watchdog on
        level2  = st_reg.sync2.always_on;
        run_eff = st_reg.run | level2
                | st_reg.cause[CAUSE_WDT];
        running = run_eff | st_reg.irq_en;

        // external pin filter: a glitch shorter than the minimum is dropped
        if (st_reg.sync2.ext_en && !st_reg.sync2.reset_n) begin
            if (st_reg.ext_cnt == EXT_MIN_COUNT) begin
                st_next.ext_active = 1'b1;
            end else begin
                st_next.ext_cnt = st_reg.ext_cnt + 10'h001;
            end
        end else begin
            st_next.ext_cnt    = '0;
            st_next.ext_active = 1'b0;
        end

        // brown-out filter, same scheme with its own duration
        if (st_reg.sync2.bod_en && st_reg.sync2.bod_low) begin
            if (st_reg.bod_cnt == BROWNOUT_MIN_COUNT) begin
                st_next.bod_active = 1'b1;
            end else begin
                st_next.bod_cnt = st_reg.bod_cnt + 10'h001;
            end
        end else begin
            st_next.bod_cnt    = '0;
            st_next.bod_active = 1'b0;
        end

        // watchdog oscillator edge, taken from the synchronised copy
        osc_edge         = st_reg.sync2.osc & ~st_reg.osc_prev;
        st_next.osc_prev = st_reg.sync2.osc;

        // watchdog counter and expiry
        expire = 1'b0;
        st_next.wdt_pulse = 1'b0;
        if (WDT_CLEAR || !running || st_reg.chip_rst) begin
            st_next.wdt_cnt = '0;
        end else if (osc_edge) begin
            if (st_reg.wdt_cnt >= wdt_limit(st_reg.period)) begin
                st_next.wdt_cnt = '0;
                expire = 1'b1;
            end else begin
                st_next.wdt_cnt = st_reg.wdt_cnt + 21'h000001;
            end
        end

        // hardware clears the interrupt flag when its vector is taken
        if (IRQ_ACK) begin
            st_next.irq_flag = 1'b0;
        end

        // unlock window runs out by itself after four clocks
        if (st_reg.unlock) begin
            if (st_reg.win_cnt == UNLOCK_LAST) begin
                st_next.unlock  = 1'b0;
                st_next.win_cnt = 3'h0;
            end else begin
                st_next.win_cnt = st_reg.win_cnt + 3'h1;
            end
        end

        // bus decode: one-cycle answer, held off while ack is up
        bus_req  = WB_CYC_I & WB_STB_I & ~st_reg.ack;
        bus_wr   = bus_req & WB_WE_I & WB_SEL_I[0];
        ctrl_wr  = bus_wr & (WB_ADR_I == ADR_CTRL) & ~st_reg.chip_rst;
        cause_wr = bus_wr & (WB_ADR_I == ADR_CAUSE);
        wbyte    = WB_DAT_I[7:0];
        w_per    = {wbyte[CTL_PER3], wbyte[CTL_PER_LO +: 3]};
        w_run    = wbyte[CTL_RUN];
        w_unlock = wbyte[CTL_UNLOCK];
        st_next.ack = bus_req;

        // control register write and the timed change sequence
        if (ctrl_wr) begin
            st_next.irq_en = wbyte[CTL_IEN];
            if (wbyte[CTL_IFLAG]) begin
                st_next.irq_flag = 1'b0;
            end
            if (st_reg.unlock && !w_unlock) begin
                // second step of the sequence, inside the window
                st_next.unlock  = 1'b0;
                st_next.win_cnt = 3'h0;
                st_next.period  = w_per;
                if (!level2) begin
                    st_next.run = w_run;
                end
            end else if (w_unlock && w_run) begin
                // first step opens or reopens the window
                st_next.unlock  = 1'b1;
                st_next.win_cnt = 3'h0;
                st_next.run     = 1'b1;
                if (!level2) begin
                    st_next.period = w_per;
                end
            end else if (!level2) begin
                // level 1: enable at will, period free, no disable
                st_next.period = w_per;
                if (w_run) begin
                    st_next.run = 1'b1;
                end
            end
        end

        // expiry action; interrupt mode takes precedence over reset
        if (expire) begin
            if (st_reg.irq_en) begin
                st_next.irq_flag = 1'b1;
                if (run_eff) begin
                    st_next.irq_en = 1'b0;
                end
            end else if (run_eff) begin
                st_next.wdt_pulse = 1'b1;
            end
        end

        // cause flags: a zero written clears, a new event wins
        if (cause_wr) begin
            st_next.cause = st_reg.cause & wbyte[3:0];
        end
        if (st_reg.wdt_pulse) begin
            st_next.cause[CAUSE_WDT] = 1'b1;
        end
        if (st_reg.bod_active) begin
            st_next.cause[CAUSE_BOD] = 1'b1;
        end
        if (st_reg.ext_active) begin
            st_next.cause[CAUSE_EXT] = 1'b1;
        end

        // reset combiner; the stretch counter restarts on every cause
        any_cause = st_reg.ext_active | st_reg.bod_active
                  | st_reg.wdt_pulse;
        if (any_cause) begin
            st_next.chip_rst  = 1'b1;
            st_next.delay_cnt = '0;
        end else if (st_reg.chip_rst) begin
            if (st_reg.delay_cnt == DELAY_LAST) begin
                st_next.chip_rst = 1'b0;
            end else begin
                st_next.delay_cnt = st_reg.delay_cnt + 24'h000001;
            end
        end

        // chip reset returns control state to its initial value
        if (st_reg.chip_rst) begin
            st_next.irq_flag = 1'b0;
            st_next.irq_en   = 1'b0;
            st_next.unlock   = 1'b0;
            st_next.win_cnt  = 3'h0;
            st_next.run      = level2;
            st_next.period   = 4'h0;
        end

        // read data registered together with ack
        st_next.rdata = 32'h00000000;
        if (bus_req && !WB_WE_I) begin
            if (WB_ADR_I == ADR_CTRL) begin
                st_next.rdata[CTL_IFLAG]        = st_reg.irq_flag;
                st_next.rdata[CTL_IEN]          = st_reg.irq_en;
                st_next.rdata[CTL_PER3]         = st_reg.period[3];
                st_next.rdata[CTL_UNLOCK]       = st_reg.unlock;
                st_next.rdata[CTL_RUN]          = run_eff;
                st_next.rdata[CTL_PER_LO +: 3]  = st_reg.period[2:0];
            end else if (WB_ADR_I == ADR_CAUSE) begin
                st_next.rdata[3:0] = st_reg.cause;
            end
        end

        // registered outputs
        // flag is set only when interrupt action was chosen, so it drives
        // the line alone; gating with the enable would hide the interrupt
        // whose expiry also clears the enable in reset-backed mode
        st_next.irq_out = st_next.irq_flag;
        st_next.bandgap = st_reg.sync2.bod_en
                        | COMPARATOR_BANDGAP_SELECT
                        | ADC_ENABLE;
    end

    // state register; supply detector acts asynchronously with no clock
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_reg          <= '0;
            st_reg.chip_rst <= 1'b1;
            st_reg.cause    <= CAUSE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // every output straight from the state register
    always_comb begin
        WB_ACK_O      = st_reg.ack;
        WB_DAT_O      = st_reg.rdata;
        CHIP_RST      = st_reg.chip_rst;
        WDT_RST_PULSE = st_reg.wdt_pulse;
        WDT_IRQ       = st_reg.irq_out;
        BANDGAP_ON    = st_reg.bandgap;
    end

endmodule : rsw_reset_wdt

// file: rtl/rsw_pkg.sv
// constants and types shared by the reset and watchdog block
package rsw_pkg;

    // system clock and timing figures
    localparam int CLK_MHZ            = 250;
    localparam int CLK_PERIOD_NS      = 4;
    localparam int STARTUP_TIMEOUT_US = 64;
    localparam int STARTUP_CYCLES     = STARTUP_TIMEOUT_US * CLK_MHZ;
    localparam int EXT_MIN_PULSE_NS   = 2500;
    localparam int EXT_MIN_CYCLES     =
        (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BROWNOUT_MIN_NS    = 2000;
    localparam int BROWNOUT_MIN_CYCLES =
        (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDT_OSC_KHZ        = 128;

    // counter and bus address widths
    localparam int FILT_W  = 10;
    localparam int DLY_W   = 24;
    localparam int WDT_W   = 21;
    localparam int ADR_W   = 4;

    localparam logic [FILT_W-1:0] EXT_MIN_COUNT =
        FILT_W'(EXT_MIN_CYCLES);
    localparam logic [FILT_W-1:0] BROWNOUT_MIN_COUNT =
        FILT_W'(BROWNOUT_MIN_CYCLES);

    // last count of the unlock window in system clocks; window is four clocks long
    localparam logic [2:0] UNLOCK_LAST = 3'h3;

    // watchdog period: 2K oscillator cycles doubled per code, 0 to 9
    localparam logic [WDT_W-1:0] WDT_BASE_CYCLES = 21'h000800;
    localparam logic [3:0]       WDT_MAX_CODE    = 4'h9;

    // register byte offsets
    localparam logic [ADR_W-1:0] ADR_CTRL  = 4'h0;
    localparam logic [ADR_W-1:0] ADR_CAUSE = 4'h4;

    // control register bit positions
    localparam int CTL_IFLAG  = 7;
    localparam int CTL_IEN    = 6;
    localparam int CTL_PER3   = 5;
    localparam int CTL_UNLOCK = 4;
    localparam int CTL_RUN    = 3;
    localparam int CTL_PER_LO = 0;

    // cause register bit positions and reset value
    localparam int CAUSE_WDT = 3;
    localparam int CAUSE_BOD = 2;
    localparam int CAUSE_EXT = 1;
    localparam int CAUSE_POR = 0;
    localparam logic [3:0] CAUSE_RESET = 4'h1;

    // inputs from outside the clock domain
    typedef struct packed {
        logic osc;
        logic reset_n;
        logic bod_low;
        logic ext_en;
        logic bod_en;
        logic always_on;
    } rsw_async_t;

    // whole state of the block
    typedef struct packed {
        rsw_async_t        sync1;
        rsw_async_t        sync2;
        logic              osc_prev;
        logic [FILT_W-1:0] ext_cnt;
        logic              ext_active;
        logic [FILT_W-1:0] bod_cnt;
        logic              bod_active;
        logic [DLY_W-1:0]  delay_cnt;
        logic              chip_rst;
        logic [WDT_W-1:0]  wdt_cnt;
        logic              wdt_pulse;
        logic              irq_flag;
        logic              irq_en;
        logic              unlock;
        logic [2:0]        win_cnt;
        logic              run;
        logic [3:0]        period;
        logic [3:0]        cause;
        logic              ack;
        logic [31:0]       rdata;
        logic              irq_out;
        logic              bandgap;
    } rsw_state_t;

endpackage : rsw_pkg

// file: verification/rsw_reset_wdt_asserts.sv
// assertion checker for the reset and watchdog block
`timescale 1ns/100ps
module rsw_reset_wdt_asserts #(
    parameter int unsigned STARTUP_CYCLES = rsw_pkg::STARTUP_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic BOD_LOW,
    input wire logic COMPARATOR_BANDGAP_SELECT,
    input wire logic ADC_ENABLE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic CHIP_RST,
    input wire logic WDT_RST_PULSE,
    input wire logic WDT_IRQ,
    input wire logic BANDGAP_ON
);
    int unsigned hi_cnt;

    // length of the present chip reset, for the stretch check
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST)
            hi_cnt <= 0;
        else
            hi_cnt <= CHIP_RST ? hi_cnt + 1 : 0;
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // watchdog pulse and the reset that follows it
    property p_pulse_one; WDT_RST_PULSE |=> !WDT_RST_PULSE; endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("watchdog pulse longer than one cycle");
    property p_pulse_rst; WDT_RST_PULSE |=> CHIP_RST; endproperty
    a_pulse_rst: assert property (p_pulse_rst)
        else $error("watchdog pulse gave no chip reset");
    property p_pulse_fall; $fell(WDT_RST_PULSE) |-> CHIP_RST[*6]; endproperty
    a_pulse_fall: assert property (p_pulse_fall)
        else $error("stretch did not start at pulse end");
    // bus answer timing
    property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack held more than one cycle");
    property p_ack_req; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("request not answered in one cycle");
    // supply detector holds chip reset on, ack and watchdog pulse off, even with no clock edge needed
    property p_rst_hold;
        disable iff (1'h0) RST |-> CHIP_RST && !WB_ACK_O && !WDT_RST_PULSE;
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("outputs not in reset during supply low");
    property p_stretch; $fell(CHIP_RST) |-> hi_cnt >= STARTUP_CYCLES;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("chip reset released before stretch");
    property p_bod_filter; $rose(BOD_LOW) && !CHIP_RST |=> !CHIP_RST[*8];
    endproperty
    a_bod_filter: assert property (p_bod_filter)
        else $error("brown-out acted on a short dip");
    property p_bg_on; COMPARATOR_BANDGAP_SELECT || ADC_ENABLE |=> BANDGAP_ON;
    endproperty
    a_bg_on: assert property (p_bg_on)
        else $error("bandgap off while requested");

    c_pulse: cover property (WDT_RST_PULSE);
    c_irq: cover property ($rose(WDT_IRQ));
    c_rel: cover property ($fell(CHIP_RST));
endmodule : rsw_reset_wdt_asserts

bind rsw_reset_wdt rsw_reset_wdt_asserts #(.STARTUP_CYCLES(STARTUP_CYCLES))
    u_asserts (.CORE_CLK(CORE_CLK), .RST(RST), .BOD_LOW(BOD_LOW),
    .COMPARATOR_BANDGAP_SELECT(COMPARATOR_BANDGAP_SELECT),
    .ADC_ENABLE(ADC_ENABLE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .CHIP_RST(CHIP_RST), .WDT_RST_PULSE(WDT_RST_PULSE),
    .WDT_IRQ(WDT_IRQ), .BANDGAP_ON(BANDGAP_ON));

// file: verification/reset_sources_and_watchdog_test.sv
// self-checking bench for the reset and watchdog block
`timescale 1ns/100ps
module reset_sources_and_watchdog_test;
    import rsw_pkg::*;
    localparam int unsigned STP = 8; // short stretch keeps the run brief
    typedef struct packed {
        logic       we;
        logic [3:0] adr;
        logic [7:0] dat; // write data, or expected read data
        logic       sel0;
        logic [3:0] gap;
    } rsw_row_t;
    logic        clk = 1'h0, rst = 1'h0, rn = 1'h1, bod = 1'h0;
    logic        bod_en = 1'h0, aon = 1'h0, osc = 1'h0, clr = 1'h0;
    logic        iack = 1'h0, cmp = 1'h0, adc = 1'h0, cyc = 1'h0;
    logic        stb = 1'h0, we = 1'h0, ext = 1'h1;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, dato, rd;
    logic        ack, chip, pulse, irq, bg;
    int          err_total = 0, comparisons = 0, n, npulse = 0;
    // level 1 rows 0..20, level 2 rows 21..28
    rsw_row_t rows [0:28] = '{
        {5'h04,8'h01,5'h10}, {5'h14,8'h00,5'h10}, {5'h04,8'h00,5'h10},
        {5'h00,8'h00,5'h10}, {5'h18,8'hFF,5'h10}, {5'h08,8'h00,5'h10},
        {5'h00,8'h00,5'h10}, {5'h10,8'h21,5'h10}, {5'h00,8'h21,5'h10},
        {5'h10,8'h07,5'h00}, {5'h00,8'h21,5'h10}, {5'h10,8'h08,5'h10},
        {5'h00,8'h08,5'h10}, {5'h10,8'h00,5'h10}, {5'h00,8'h08,5'h10},
        {5'h10,8'h18,5'h16}, {5'h10,8'h00,5'h10}, {5'h00,8'h08,5'h10},
        {5'h10,8'h18,5'h10}, {5'h10,8'h03,5'h10}, {5'h00,8'h03,5'h10},
        {5'h00,8'h08,5'h10}, {5'h10,8'h00,5'h10}, {5'h00,8'h08,5'h10},
        {5'h10,8'h02,5'h10}, {5'h00,8'h08,5'h10}, {5'h10,8'h18,5'h10},
        {5'h10,8'h02,5'h10}, {5'h00,8'h0A,5'h10}};

    rsw_reset_wdt #(.STARTUP_CYCLES(STP)) u_dut (
        .CORE_CLK(clk), .RST(rst), .RESET_N_PIN(rn), .EXT_RESET_EN(ext),
        .BOD_LOW(bod), .BOD_EN_FUSE(bod_en), .ALWAYS_ON_FUSE(aon),
        .WDT_OSC(osc), .WDT_CLEAR(clr), .IRQ_ACK(iack),
        .COMPARATOR_BANDGAP_SELECT(cmp), .ADC_ENABLE(adc), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat), .WB_ACK_O(ack), .WB_DAT_O(dato), .CHIP_RST(chip),
        .WDT_RST_PULSE(pulse), .WDT_IRQ(irq), .BANDGAP_ON(bg));

    // clocks: core at 4 ns, watchdog oscillator sped up to save run time
    initial forever #2 clk = ~clk;
    initial forever begin
        repeat (2) @(posedge clk);
        osc <= ~osc;
    end
    // count watchdog reset pulses
    always @(posedge clk)
        if (pulse === 1'h1)
            npulse <= npulse + 1;
    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        test_done();
    end

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // one classic cycle; held until ack is sampled high
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        // no cycle count assumed; only the hang guard ends this wait
        while (ack !== 1'h1)
            @(posedge clk);
        rd = dato;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : bus

    task automatic run(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            bus(rows[i].we, rows[i].adr, {24'h0, rows[i].dat},
                {3'h0, rows[i].sel0});
            if (!rows[i].we)
                chk("reg", rd, {24'h0, rows[i].dat});
            repeat (rows[i].gap) @(posedge clk);
        end
    endtask : run

    // bounded wait for the chip reset to let go
    task automatic rel();
        for (n = 0; n < 3000 && chip !== 1'h0; n++)
            @(posedge clk);
    endtask : rel

    // pin low or supply dip of a given length
    task automatic dip(input logic b, input int len, input logic e);
        if (b)
            bod <= 1'h1;
        else
            rn <= 1'h0;
        repeat (len) @(posedge clk);
        bod <= 1'h0;
        rn <= 1'h1;
        repeat (4) @(posedge clk);
        chk("dip", chip, e);
        rel();
    endtask : dip

    task automatic test_done();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    initial begin
        rst <= 1'h1; // edge at time zero so state is known at first clock
        repeat (16) @(posedge clk);
        chk("por", chip, 1'h1);
        chk("por_ack", ack, 1'h0);
        rst <= 1'h0;
        rel();
        run(0, 20);
        // interrupt-only expiry
        bus(1'h1, 4'h0, 32'h40, 4'h1);
        for (n = 0; n < 12000 && irq !== 1'h1; n++) @(posedge clk);
        chk("irq", irq, 1'h1);
        chk("pulses", npulse, 0);
        bus(1'h0, 4'h0, 32'h0, 4'h1);
        chk("ctrl", rd, 32'hC0);
        iack <= 1'h1;
        @(posedge clk);
        iack <= 1'h0;
        repeat (3) @(posedge clk);
        chk("irq", irq, 1'h0);
        // interrupt then reset, with a clear part way
        bus(1'h1, 4'h0, 32'h48, 4'h1);
        repeat (6000) @(posedge clk);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        for (n = 6000; n < 40000 && irq !== 1'h1; n++) @(posedge clk);
        chk("irq_first", irq, 1'h1);
        while (n < 40000 && pulse !== 1'h1) begin
            @(posedge clk);
            n++;
        end
        chk("late", n > 20000, 1'h1);
        @(posedge clk);
        chk("chip", chip, 1'h1);
        rel();
        chk("stretch", n, STP);
        bus(1'h0, 4'h4, 32'h0, 4'h1);
        chk("cause", rd, 32'h08);
        bus(1'h0, 4'h0, 32'h0, 4'h1);
        chk("run", rd[3], 1'h1);
        // second reset at safety level 2
        aon <= 1'h1;
        rst <= 1'h1;
        repeat (16) @(posedge clk);
        chk("por2", chip, 1'h1);
        rst <= 1'h0;
        rel();
        run(21, 28);
        bod_en <= 1'h1;
        ext <= 1'h0;
        dip(1'h0, 700, 1'h0);
        ext <= 1'h1;
        dip(1'h0, 300, 1'h0);
        dip(1'h0, 700, 1'h1);
        dip(1'h1, 300, 1'h0);
        dip(1'h1, 700, 1'h1);
        bus(1'h0, 4'h4, 32'h0, 4'h1);
        chk("cause", rd, 32'h07);
        // every bandgap request combination
        for (int i = 0; i < 8; i++) begin
            bod_en <= i[2];
            cmp <= i[1];
            adc <= i[0];
            repeat (5) @(posedge clk);
            chk("bandgap", bg, i != 0);
        end
        test_done();
    end
endmodule : reset_sources_and_watchdog_test
